// ---- rtl/i2csw_pkg.sv ----
/*
 * Package for the four-channel I2C switch control block: register layout,
 * reset value, address layout and the slave state machine encoding.
 * Assumes a single 250 MHz system clock; SCL and SDA are oversampled pins.
 */
package i2csw_pkg;

    // Channel count and control register layout
    localparam int          NUM_CHAN      = 4;
    localparam int          CTRL_EN_LSB   = 0;
    localparam int          CTRL_IRQ_LSB  = 4;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;

    // Slave address: fixed upper five bits, two strap bits below
    localparam logic [4:0]  ADDR_FIXED    = 5'h0e;
    localparam int          ADDR_RW_BIT   = 0;

    // Bit counter limits
    localparam logic [3:0]  BIT_LAST      = 4'h7;

    // Slave state machine, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b00_0001,
        ST_ADDR  = 6'b00_0010,
        ST_AACK  = 6'b00_0100,
        ST_WDATA = 6'b00_1000,
        ST_WACK  = 6'b01_0000,
        ST_RDATA = 6'b10_0000
    } i2csw_state_t;

    // Bus events decoded from the synchronised pins
    typedef struct packed {
        logic start;
        logic stop;
        logic sclRise;
        logic sclFall;
        logic sda;
    } i2csw_bus_t;

    // Whole state of the controller
    typedef struct packed {
        i2csw_state_t st;
        logic [3:0]   bitCnt;
        logic [7:0]   shift;
        logic [3:0]   pendEn;
        logic         pendValid;
        logic [3:0]   chanEn;
        logic         sdaOe;
        logic         rdAck;
        logic         irqOe;
    } i2csw_regs_t;

endpackage : i2csw_pkg

// ---- rtl/i2csw_pin_sync.sv ----
/*
 * Two-flop synchroniser and start/stop/edge detector for SCL and SDA.
 * Assumes pins are asynchronous to clock; the detector reads only the
 * two history stages after the second flop.
 */
`timescale 1ns/10ps
module i2csw_pin_sync
    import i2csw_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output i2csw_pkg::i2csw_bus_t busEv
);
    import i2csw_pkg::*;

    typedef struct packed {
        logic [1:0] sclMeta;
        logic [1:0] sdaMeta;
        logic [1:0] sclHist;
        logic [1:0] sdaHist;
    } i2csw_sync_t;

    i2csw_sync_t s_q;
    i2csw_sync_t s_d;

    // Shift pins through metastability flops then two history stages
    always_comb begin
        s_d         = s_q;
        s_d.sclMeta = {s_q.sclMeta[0], sclIn};
        s_d.sdaMeta = {s_q.sdaMeta[0], sdaIn};
        s_d.sclHist = {s_q.sclHist[0], s_q.sclMeta[1]};
        s_d.sdaHist = {s_q.sdaHist[0], s_q.sdaMeta[1]};
    end

    // Idle bus is high on both lines
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_q <= '1;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    // Start: SDA falls while SCL high; stop: SDA rises while SCL high
    always_comb begin
        busEv.start   = s_q.sclHist[0] & s_q.sclHist[1] & s_q.sdaHist[1] & ~s_q.sdaHist[0];
        busEv.stop    = s_q.sclHist[0] & s_q.sclHist[1] & ~s_q.sdaHist[1] & s_q.sdaHist[0];
        busEv.sclRise = s_q.sclHist[0] & ~s_q.sclHist[1];
        busEv.sclFall = ~s_q.sclHist[0] & s_q.sclHist[1];
        busEv.sda     = s_q.sdaHist[0];
    end

endmodule : i2csw_pin_sync

// ---- rtl/i2csw_ctrl.sv ----
/*
 * Control logic of a four-channel I2C switch: slave address match, one
 * control register, channel enables applied at stop, interrupt status.
 * Assumes SCL/SDA/interrupt pins are asynchronous; the wired level of
 * SDA and the interrupt line is resolved outside from the enables.
 */
// How it works
// - Address bit zero set means read, clear means write.
// - After an acknowledged write address the next byte goes to the register.
// - Several written bytes in one transfer: the last one is kept.
// - The control register can be both written and read over the bus.
// - Low bit n enables channel n when one, disables it when zero.
// - Any combination of the four channels may be enabled at once.
// - A new selection connects channels only once a stop is seen.
// - Reset leaves every control bit zero and no channel selected.
// - Any asserted interrupt input pulls the interrupt output low.
// - Interrupt detection works whether or not the channel is selected.
// - Register bits 4 to 7 report interrupts of channels 0 to 3.
// - A read loads the inverted present interrupt input levels into the upper bits.
// - Status bit is one for an active interrupt, zero otherwise.
// - Any number of channels may show interrupting at the same time.
// - Interrupt inputs may serve as general inputs read in the upper bits.
// - Holding the reset pin low clears registers, state machine and channels.
// - Power-on reset clears registers to zero and returns the state machine to idle.
`timescale 1ns/10ps
module i2csw_ctrl
    import i2csw_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 clkEn,
    input  wire logic                 resetPinN,
    input  wire logic                 addr_sel_lo,
    input  wire logic                 addr_sel_hi,
    input  wire logic                 sclIn,
    input  wire logic                 sdaIn,
    output logic                      sdaOut,
    output logic                      sdaOe,
    input  wire logic                 chan0_irq_in_n,
    input  wire logic                 chan1_irq_in_n,
    input  wire logic                 chan2_irq_in_n,
    input  wire logic                 chan3_irq_in_n,
    output logic                      irqOut,
    output logic                      irqOe,
    output logic [NUM_CHAN-1:0]       downstream_pair
);
    import i2csw_pkg::*;

    i2csw_bus_t  busEv;
    i2csw_regs_t r_q;
    i2csw_regs_t r_d;
    logic [1:0]  rstMeta;
    logic [1:0]  strapLo;
    logic [1:0]  strapHi;
    logic [3:0]  irqMeta;
    logic [3:0]  irqSync;
    logic [3:0]  irqRaw;
    logic [3:0]  irqAct;
    logic        pinRst;
    logic [6:0]  myAddr;

    // Pin synchroniser and bus event decoder
    i2csw_pin_sync u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .busEv   (busEv)
    );

    assign irqRaw = {chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n};

    // Two-flop synchronisers for reset pin, address straps and interrupt pins
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rstMeta <= 2'h0;
            strapLo <= 2'h0;
            strapHi <= 2'h0;
            irqMeta <= 4'hf;
            irqSync <= 4'hf;
        end else if (clkEn) begin
            rstMeta <= {rstMeta[0], resetPinN};
            strapLo <= {strapLo[0], addr_sel_lo};
            strapHi <= {strapHi[0], addr_sel_hi};
            irqMeta <= irqRaw;
            irqSync <= irqMeta;
        end
    end

    assign pinRst = ~rstMeta[1];
    assign irqAct = ~irqSync;
    assign myAddr = {ADDR_FIXED, strapHi[1], strapLo[1]};

    // Next-state logic of the serial slave
    always_comb begin
        r_d       = r_q;
        r_d.irqOe = |irqAct;
        if (busEv.start) begin
            r_d.st     = ST_ADDR;
            r_d.bitCnt = 4'h0;
            r_d.sdaOe  = 1'b0;
        end else if (busEv.stop) begin
            r_d.st    = ST_IDLE;
            r_d.sdaOe = 1'b0;
            if (r_q.pendValid) begin
                r_d.chanEn    = r_q.pendEn;
                r_d.pendValid = 1'b0;
            end
        end else begin
            case (r_q.st)
                ST_IDLE: begin
                    r_d.sdaOe = 1'b0;
                end
                ST_ADDR: begin
                    if (busEv.sclRise) begin
                        r_d.shift  = {r_q.shift[6:0], busEv.sda};
                        r_d.bitCnt = r_q.bitCnt + 4'h1;
                    end
                    if (busEv.sclFall && r_q.bitCnt == 4'h8) begin
                        if (r_q.shift[7:1] == myAddr) begin
                            r_d.st    = ST_AACK;
                            r_d.sdaOe = 1'b1;
                        end else begin
                            r_d.st = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (busEv.sclFall) begin
                        r_d.bitCnt = 4'h0;
                        if (r_q.shift[ADDR_RW_BIT]) begin
                            r_d.st    = ST_RDATA;
                            r_d.shift = {irqAct, r_q.chanEn};
                            r_d.sdaOe = ~irqAct[3];
                        end else begin
                            r_d.st    = ST_WDATA;
                            r_d.sdaOe = 1'b0;
                        end
                    end
                end
                ST_WDATA: begin
                    if (busEv.sclRise) begin
                        r_d.shift  = {r_q.shift[6:0], busEv.sda};
                        r_d.bitCnt = r_q.bitCnt + 4'h1;
                    end
                    if (busEv.sclFall && r_q.bitCnt == 4'h8) begin
                        r_d.pendEn    = r_q.shift[CTRL_EN_LSB +: NUM_CHAN];
                        r_d.pendValid = 1'b1;
                        r_d.st        = ST_WACK;
                        r_d.sdaOe     = 1'b1;
                    end
                end
                ST_WACK: begin
                    if (busEv.sclFall) begin
                        r_d.st     = ST_WDATA;
                        r_d.bitCnt = 4'h0;
                        r_d.sdaOe  = 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (busEv.sclFall) begin
                        if (r_q.bitCnt < BIT_LAST) begin
                            r_d.bitCnt = r_q.bitCnt + 4'h1;
                            r_d.shift  = {r_q.shift[6:0], 1'b0};
                            r_d.sdaOe  = ~r_q.shift[6];
                        end else if (r_q.bitCnt == BIT_LAST) begin
                            r_d.bitCnt = r_q.bitCnt + 4'h1;
                            r_d.sdaOe  = 1'b0;
                        end else if (r_q.rdAck) begin
                            r_d.bitCnt = 4'h0;
                            r_d.shift  = {irqAct, r_q.chanEn};
                            r_d.sdaOe  = ~irqAct[3];
                        end else begin
                            r_d.st = ST_IDLE;
                        end
                    end
                    if (busEv.sclRise && r_q.bitCnt == 4'h8) begin
                        r_d.rdAck = ~busEv.sda;
                    end
                end
                default: begin
                    r_d.st = ST_IDLE;
                end
            endcase
        end
    end

    // State register; system reset clears all, the pin reset all but the interrupt output
    always_ff @(posedge clock) begin
        if (sys_rst || pinRst) begin
            // Interrupt output keeps following the pins while only the reset pin is low
            r_q <= '{st: ST_IDLE, irqOe: (|irqAct) & ~sys_rst, default: '0};
        end else if (clkEn) begin
            r_q <= r_d;
        end
    end

    assign sdaOut          = 1'b0;
    assign sdaOe           = r_q.sdaOe;
    assign irqOut          = 1'b0;
    assign irqOe           = r_q.irqOe;
    assign downstream_pair = r_q.chanEn;

    // Channels change only on a stop
    property p_chanAtStop;
        @(posedge clock) disable iff (sys_rst || pinRst)
        (clkEn && $changed(r_q.chanEn)) |-> $past(busEv.stop);
    endproperty
    a_chanAtStop: assert property (p_chanAtStop) else $error("channels changed without stop");

    // Interrupt output follows synchronised inputs one cycle later, under the reset pin too
    property p_irqOut;
        @(posedge clock) disable iff (sys_rst)
        $past(clkEn) |-> (irqOe == |$past(irqAct));
    endproperty
    a_irqOut: assert property (p_irqOut) else $error("interrupt output wrong");

    // Reset clears channel selection
    property p_resetClear;
        @(posedge clock) (!sys_rst && $past(sys_rst)) |-> (downstream_pair == 4'h0 && !sdaOe);
    endproperty
    a_resetClear: assert property (p_resetClear) else $error("reset did not clear");

    // Foreign address never acknowledged
    property p_noForeignAck;
        @(posedge clock) disable iff (sys_rst || pinRst)
        (r_q.st == ST_AACK) |-> (r_q.shift[7:1] == myAddr);
    endproperty
    a_noForeignAck: assert property (p_noForeignAck) else $error("foreign address acked");

    // Read loads interrupt status into upper bits
    sequence s_readLoad;
        clkEn && r_q.st == ST_AACK && busEv.sclFall && r_q.shift[0] && !busEv.start && !busEv.stop;
    endsequence
    property p_readLoad;
        @(posedge clock) disable iff (sys_rst || pinRst)
        s_readLoad |=> (r_q.shift[7:4] == $past(irqAct) && r_q.shift[3:0] == r_q.chanEn);
    endproperty
    a_readLoad: assert property (p_readLoad) else $error("read byte wrong");

    // Write byte captured into pending enables, low bits only
    sequence s_wrDone;
        clkEn && r_q.st == ST_WDATA && busEv.sclFall && r_q.bitCnt == 4'h8
            && !busEv.start && !busEv.stop;
    endsequence
    property p_wrCapture;
        @(posedge clock) disable iff (sys_rst || pinRst)
        s_wrDone |=> (r_q.pendEn == $past(r_q.shift[3:0]) && r_q.pendValid && sdaOe);
    endproperty
    a_wrCapture: assert property (p_wrCapture) else $error("write byte not captured");

    // Pending selection applied at stop
    property p_applyStop;
        @(posedge clock) disable iff (sys_rst || pinRst)
        (clkEn && busEv.stop && r_q.pendValid) |=> (downstream_pair == $past(r_q.pendEn));
    endproperty
    a_applyStop: assert property (p_applyStop) else $error("selection not applied");

    // Write direction never drives read data
    property p_dirWrite;
        @(posedge clock) disable iff (sys_rst || pinRst)
        (clkEn && r_q.st == ST_AACK && busEv.sclFall && !r_q.shift[0]
            && !busEv.start && !busEv.stop) |=> (r_q.st == ST_WDATA && !sdaOe);
    endproperty
    a_dirWrite: assert property (p_dirWrite) else $error("write direction wrong");

    // Foreign address left alone: no acknowledge, back to idle
    sequence s_addrMiss;
        clkEn && r_q.st == ST_ADDR && busEv.sclFall && r_q.bitCnt == 4'h8
            && r_q.shift[7:1] != myAddr && !busEv.start && !busEv.stop;
    endsequence
    property p_addrMiss;
        @(posedge clock) disable iff (sys_rst || pinRst)
        s_addrMiss |=> (r_q.st == ST_IDLE && !sdaOe);
    endproperty
    a_addrMiss: assert property (p_addrMiss) else $error("foreign address not ignored");

    // Acknowledge of a written byte lasts one bit, then a further byte may follow
    property p_wrAckRelease;
        @(posedge clock) disable iff (sys_rst || pinRst)
        (clkEn && r_q.st == ST_WACK && busEv.sclFall && !busEv.start && !busEv.stop)
            |=> (r_q.st == ST_WDATA && !sdaOe && r_q.pendValid);
    endproperty
    a_wrAckRelease: assert property (p_wrAckRelease) else $error("write ack not released");

    // Reset pin holds the switch deselected and the serial slave idle
    property p_pinReset;
        @(posedge clock) disable iff (sys_rst)
        $past(pinRst) |-> (downstream_pair == 4'h0 && !sdaOe && r_q.st == ST_IDLE);
    endproperty
    a_pinReset: assert property (p_pinReset) else $error("reset pin did not clear");

    // Master acknowledge of a read byte reloads live status for the next one
    sequence s_readAgain;
        clkEn && r_q.st == ST_RDATA && busEv.sclFall && r_q.bitCnt == 4'h8 && r_q.rdAck
            && !busEv.start && !busEv.stop;
    endsequence
    property p_readAgain;
        @(posedge clock) disable iff (sys_rst || pinRst)
        s_readAgain |=> (r_q.shift == {$past(irqAct), r_q.chanEn} && r_q.bitCnt == 4'h0);
    endproperty
    a_readAgain: assert property (p_readAgain) else $error("read byte not reloaded");

endmodule : i2csw_ctrl

// ---- tb/i2csw_master_model.sv ----
/*
 * Behavioural upstream I2C master driving SCL and pulling SDA low.
 * Assumes the bench resolves the wired SDA level with a pull-up.
 */
`timescale 1ns/10ps
module i2csw_master_model (
    input  wire logic clock,
    input  wire logic sdaLine,
    output logic      sclOut,
    output logic      sdaDrvLow
);
    // Quarter of a bit period in clock cycles
    localparam int PH = 4;

    // Bus idles high
    initial begin
        sclOut    = 1'b1;
        sdaDrvLow = 1'b0;
    end

    // Let whole cycles pass, then step off the edge
    task automatic waitCyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : waitCyc

    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        sdaDrvLow = 1'b0;
        waitCyc(PH);
        sclOut = 1'b1;
        waitCyc(2*PH);
        sdaDrvLow = 1'b1;
        waitCyc(2*PH);
        sclOut = 1'b0;
    endtask : start

    // One bit: data changes only while SCL is low
    task automatic bitX(input logic b, output logic s);
        waitCyc(PH);
        sdaDrvLow = ~b;
        waitCyc(PH);
        sclOut = 1'b1;
        waitCyc(2*PH);
        s = sdaLine;
        sclOut = 1'b0;
    endtask : bitX

    // Byte MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] wb, input logic ackDrv, output logic [7:0] rb,
                        output logic ackN);
        for (int i = 7; i >= 0; i--) begin
            bitX(wb[i], rb[i]);
        end
        bitX(~ackDrv, ackN);
    endtask : xfer

    // Stop right after the acknowledge: SDA rises while SCL is high
    task automatic stop();
        waitCyc(PH);
        sdaDrvLow = 1'b1;
        waitCyc(PH);
        sclOut = 1'b1;
        waitCyc(2*PH);
        sdaDrvLow = 1'b0;
        waitCyc(2*PH);
    endtask : stop
endmodule : i2csw_master_model

// ---- tb/tb_i2csw_ctrl.sv ----
/*
 * Self-checking bench for the switch control block.
 * Assumes straps hi=1, lo=0 and pull-ups on the wired SDA and interrupt lines.
 */
`timescale 1ns/10ps
module tb_i2csw_ctrl;
    import i2csw_pkg::*;
    localparam logic [7:0] WR_ADDR  = {ADDR_FIXED, 2'b10, 1'b0};
    localparam logic [7:0] RD_ADDR  = {ADDR_FIXED, 2'b10, 1'b1};
    localparam logic [7:0] BAD_ADDR = {ADDR_FIXED, 2'b01, 1'b0};
    logic                clock     = 1'b0;
    logic                sys_rst   = 1'b1;
    logic                resetPinN = 1'b1;
    logic [3:0]          irqN      = 4'hf;
    logic [3:0]          expPair   = 4'h0;
    logic [3:0]          irqPat [4] = '{4'he, 4'h9, 4'h0, 4'hf};
    logic                sclLine;
    logic                sdaDrvLow;
    logic                sdaOe;
    logic                irqOe;
    logic                sdaOut;
    logic                irqOut;
    logic [NUM_CHAN-1:0] downstream_pair;
    int                  badCount       = 0;
    int                  samplesChecked = 0;
    // Wired lines: a driver enabled by its output enable wins over the pull-up
    wire logic           sdaLine  = ~sdaDrvLow & (~sdaOe | sdaOut);
    wire logic           irqLineN = ~irqOe | irqOut;

    // 250 MHz clock
    always #2 clock = ~clock;

    i2csw_ctrl dut (
        .clock(clock), .sys_rst(sys_rst), .clkEn(1'b1), .resetPinN(resetPinN),
        .addr_sel_lo(1'b0), .addr_sel_hi(1'b1), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .chan0_irq_in_n(irqN[0]), .chan1_irq_in_n(irqN[1]),
        .chan2_irq_in_n(irqN[2]), .chan3_irq_in_n(irqN[3]), .irqOut(irqOut), .irqOe(irqOe),
        .downstream_pair(downstream_pair)
    );

    i2csw_master_model master (
        .clock(clock), .sdaLine(sdaLine), .sclOut(sclLine), .sdaDrvLow(sdaDrvLow)
    );

    // Compare and count
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Report and end the run
    task automatic stopTest();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stopTest

    // Let cycles pass, then step off the edge
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle

    // Write transfer of nb bytes, then stop
    task automatic wrReg(input logic [7:0] addr, input logic [7:0] d0, input logic [7:0] d1,
                         input int nb);
        logic [7:0] rb;
        logic       ackN;
        master.start();
        master.xfer(addr, 1'b0, rb, ackN);
        check("address ack", {7'h0, addr != WR_ADDR}, {7'h0, ackN});
        if (nb > 0) master.xfer(d0, 1'b0, rb, ackN);
        if (nb > 1) master.xfer(d1, 1'b0, rb, ackN);
        check("pair before stop", {4'h0, expPair}, {4'h0, downstream_pair});
        master.stop();
        if (addr == WR_ADDR && nb > 0) expPair = (nb > 1) ? d1[3:0] : d0[3:0];
        idle(8);
        check("channel enables", {4'h0, expPair}, {4'h0, downstream_pair});
    endtask : wrReg

    // Read two bytes, acknowledging the first
    task automatic rdReg(input logic [7:0] exp);
        logic [7:0] rb;
        logic       ackN;
        master.start();
        master.xfer(RD_ADDR, 1'b0, rb, ackN);
        check("read address ack", 8'h00, {7'h0, ackN});
        master.xfer(8'hff, 1'b1, rb, ackN);
        check("read byte", exp, rb);
        master.xfer(8'hff, 1'b0, rb, ackN);
        check("reloaded byte", exp, rb);
        master.stop();
        idle(4);
    endtask : rdReg

    // Main sequence
    initial begin
        idle(6);
        sys_rst = 1'b0;
        idle(8);
        check("pair after reset", 8'h00, {4'h0, downstream_pair});
        rdReg(8'h00);
        for (int v = 0; v < 16; v++) begin
            wrReg(WR_ADDR, {4'ha, v[3:0]}, 8'h00, 1);
        end
        rdReg(8'h0f);
        wrReg(WR_ADDR, 8'h03, 8'h09, 2);
        wrReg(BAD_ADDR, 8'h06, 8'h00, 1);
        wrReg(WR_ADDR, 8'h00, 8'h00, 1);
        foreach (irqPat[i]) begin
            irqN = irqPat[i];
            idle(8);
            check("irq output", {7'h0, irqPat[i] != 4'hf}, {7'h0, ~irqLineN});
            rdReg({~irqPat[i], expPair});
        end
        // Service: read status, select the channel, clear the source
        irqN = 4'hd;
        idle(8);
        rdReg({4'h2, expPair});
        wrReg(WR_ADDR, 8'h02, 8'h00, 1);
        irqN = 4'hf;
        idle(8);
        check("irq released", 8'h00, {7'h0, ~irqLineN});
        rdReg({4'h0, expPair});
        resetPinN = 1'b0;
        idle(6);
        resetPinN = 1'b1;
        idle(8);
        expPair = 4'h0;
        check("pair after pin reset", 8'h00, {4'h0, downstream_pair});
        rdReg(8'h00);
        wrReg(WR_ADDR, 8'h0f, 8'h00, 1);
        sys_rst = 1'b1;
        idle(6);
        sys_rst = 1'b0;
        idle(8);
        expPair = 4'h0;
        check("pair after second reset", 8'h00, {4'h0, downstream_pair});
        rdReg(8'h00);
        stopTest();
    end

    // Cut a hang short
    initial begin
        repeat (100000) @(posedge clock);
        badCount++;
        stopTest();
    end
endmodule : tb_i2csw_ctrl
